// file: isr_ctrl.v
// Host controller driving the start, reservation and slave handshake of a two-wire bus controller
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "isr_defines.vh"
module isr_ctrl #(
	parameter FRAME_CYCLES = (`ISR_FRAME_NS + `ISR_CLK_NS - 1) / `ISR_CLK_NS
) (
	// Clock and reset
	input  wire        clk_sys,
	input  wire        resetn,
	// Avalon-MM slave
	input  wire [2:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest,
	output reg         irq,
	// Bus lines, observed only
	input  wire        serial_clock_line,
	input  wire        serial_data_line,
	// Controls to the bus controller
	output reg         controller_enable,
	output reg         reservation_disable,
	output reg         initial_bus_state_option,
	output reg         stop_irq_enable,
	output reg         clock_extend_select,
	output reg         speed_mode_select,
	output reg         clock_select_hi,
	output reg         clock_select_lo,
	output reg         start_request,
	output reg         stop_request,
	output reg         bus_release_request,
	output reg         shift_data_write,
	output reg  [7:0]  shift_data_reg,
	output reg         ack_enable,
	// Status from the bus controller
	input  wire        master_state_flag,
	input  wire        start_detected_flag,
	input  wire        start_rejected_flag,
	input  wire        bus_busy_flag,
	input  wire        stop_detected_flag,
	input  wire        ack_detected_flag,
	input  wire        transmit_direction_flag,
	input  wire        transfer_event_irq,
	input  wire [7:0]  shift_data_in
);
	localparam ST_IDLE     = 3'h0;
	localparam ST_ENABLE   = 3'h1;
	localparam ST_FREE     = 3'h2;
	localparam ST_READY    = 3'h3;
	localparam ST_START    = 3'h4;
	localparam ST_WAITFLAG = 3'h5;
	localparam ST_RESERVED = 3'h6;
	localparam ST_MASTER   = 3'h7;

	// Table lookups for the flag wait periods
	function [7:0] master_wait;
		input [3:0] sel;
		begin
			case (sel)
				4'h0:       master_wait = `ISR_MW_0;
				4'h1:       master_wait = `ISR_MW_1;
				4'h2:       master_wait = `ISR_MW_2;
				4'h3:       master_wait = `ISR_MW_3;
				4'h4, 4'h5: master_wait = `ISR_MW_45;
				4'h6:       master_wait = `ISR_MW_6;
				4'h7:       master_wait = `ISR_MW_7;
				4'hC, 4'hD: master_wait = `ISR_MW_CD;
				4'hE:       master_wait = `ISR_MW_E;
				default:    master_wait = `ISR_MW_3;
			endcase
		end
	endfunction

	function [7:0] reject_wait;
		input [1:0] sel;
		begin
			case (sel)
				2'h2:    reject_wait = `ISR_RW_FULL;
				2'h3:    reject_wait = `ISR_RW_THIRD;
				default: reject_wait = `ISR_RW_HALF;
			endcase
		end
	endfunction

	reg  [2:0]             state;
	reg  [10:0]            ctrl;
	reg  [`ISR_EV_W-1:0]   irq_status;
	reg  [`ISR_EV_W-1:0]   irq_mask;
	reg  [7:0]             slv_rx_count;
	reg  [7:0]             slv_rx_left;
	reg  [7:0]             rx_data;
	reg  [7:0]             tx_byte;
	reg                    tx_pending;
	reg                    start_pend;
	reg                    stop_pend;
	reg                    release_pend;
	reg                    first_start;
	reg  [2:0]             outcome;
	reg  [15:0]            idle_count;
	reg                    bus_idle;
	reg                    event_prev;
	reg                    slave_active;
	reg                    timer_load;
	reg  [7:0]             timer_count;
	reg  [`ISR_EV_W-1:0]   events;
	wire [1:0]             lines;
	wire                   timer_done;
	wire                   event_pulse;
	wire                   acc;
	wire                   wr_ok;
	wire                   need_idle;
	wire [3:0]             clk_sel;

	isr_sync #(
		.WIDTH    (2)
	) u_sync (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.async_in ({serial_clock_line, serial_data_line}),
		.sync_out (lines)
	);

	isr_timer #(
		.WIDTH    (8)
	) u_timer (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.load     (timer_load),
		.count    (timer_count),
		.done     (timer_done)
	);

	assign clk_sel     = {clock_extend_select, speed_mode_select, clock_select_hi, clock_select_lo};
	assign event_pulse = transfer_event_irq & ~event_prev;
	assign need_idle   = ctrl[`ISR_CTRL_MULTI] | (initial_bus_state_option & first_start);
	// A second byte stalls the bus until the first has gone
	assign acc   = (avs_read | avs_write) & avs_waitrequest &
		~(avs_write & (avs_address == `ISR_REG_TXDATA) & tx_pending);
	assign wr_ok = avs_write & ~avs_waitrequest;

	// Bus slave handshake and read data
	always @(posedge clk_sys) begin
		if (!resetn) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h00000000;
		end else begin
			avs_waitrequest <= ~acc;
			if (acc && avs_read) begin
				case (avs_address)
					`ISR_REG_CTRL:     avs_readdata <= {21'h000000, 3'h0, ctrl[7:0]};
					`ISR_REG_STATUS:   avs_readdata <= {21'h000000, state, 1'b0, tx_pending,
						master_state_flag, bus_busy_flag, bus_idle, outcome};
					`ISR_REG_IRQ_STAT: avs_readdata <= {26'h0000000, irq_status};
					`ISR_REG_IRQ_MASK: avs_readdata <= {26'h0000000, irq_mask};
					`ISR_REG_SLV_CFG:  avs_readdata <= {24'h000000, slv_rx_count};
					`ISR_REG_RXDATA:   avs_readdata <= {24'h000000, rx_data};
					default:           avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Software registers, commands and sticky interrupt status
	always @(posedge clk_sys) begin
		if (!resetn) begin
			ctrl         <= `ISR_CTRL_RESET;
			irq_mask     <= {`ISR_EV_W{1'b0}};
			irq_status   <= {`ISR_EV_W{1'b0}};
			slv_rx_count <= 8'h00;
			irq          <= 1'b0;
		end else begin
			if (wr_ok && avs_address == `ISR_REG_CTRL)
				ctrl <= {3'h0, avs_writedata[7:0]};
			if (wr_ok && avs_address == `ISR_REG_IRQ_MASK)
				irq_mask <= avs_writedata[`ISR_EV_W-1:0];
			if (wr_ok && avs_address == `ISR_REG_SLV_CFG)
				slv_rx_count <= avs_writedata[7:0];
			// A new event wins over a clearing write in the same cycle
			if (wr_ok && avs_address == `ISR_REG_IRQ_STAT)
				irq_status <= (irq_status & ~avs_writedata[`ISR_EV_W-1:0]) | events;
			else
				irq_status <= irq_status | events;
			irq <= |(irq_status & irq_mask);
		end
	end

	// Bus idle detector for multimaster use and first start
	always @(posedge clk_sys) begin
		if (!resetn) begin
			idle_count <= 16'h0000;
			bus_idle   <= 1'b0;
		end else if (lines != 2'b11) begin
			idle_count <= 16'h0000;
			bus_idle   <= 1'b0;
		end else if (idle_count >= FRAME_CYCLES[15:0] - 16'h0001) begin
			bus_idle   <= 1'b1;
		end else begin
			idle_count <= idle_count + 16'h0001;
		end
	end

	// Main sequencer
	always @(posedge clk_sys) begin
		if (!resetn) begin
			state                    <= ST_IDLE;
			controller_enable        <= 1'b0;
			reservation_disable      <= 1'b0;
			initial_bus_state_option <= 1'b0;
			stop_irq_enable          <= 1'b0;
			clock_extend_select      <= 1'b0;
			speed_mode_select        <= 1'b0;
			clock_select_hi          <= 1'b0;
			clock_select_lo          <= 1'b0;
			start_request            <= 1'b0;
			stop_request             <= 1'b0;
			bus_release_request      <= 1'b0;
			shift_data_write         <= 1'b0;
			shift_data_reg           <= 8'h00;
			ack_enable               <= 1'b1;
			tx_byte                  <= 8'h00;
			tx_pending               <= 1'b0;
			start_pend               <= 1'b0;
			stop_pend                <= 1'b0;
			release_pend             <= 1'b0;
			first_start              <= 1'b1;
			outcome                  <= 3'h0;
			event_prev               <= 1'b0;
			slave_active             <= 1'b0;
			slv_rx_left              <= 8'h00;
			rx_data                  <= 8'h00;
			timer_load               <= 1'b0;
			timer_count              <= 8'h00;
			events                   <= {`ISR_EV_W{1'b0}};
		end else begin
			// Request bits are single pulses, so each is low again before reuse
			start_request       <= 1'b0;
			stop_request        <= 1'b0;
			bus_release_request <= 1'b0;
			shift_data_write    <= 1'b0;
			timer_load          <= 1'b0;
			events              <= {`ISR_EV_W{1'b0}};
			event_prev          <= transfer_event_irq;
			if (wr_ok && avs_address == `ISR_REG_TXDATA) begin
				tx_byte    <= avs_writedata[7:0];
				tx_pending <= 1'b1;
			end
			if (wr_ok && avs_address == `ISR_REG_CTRL) begin
				if (avs_writedata[`ISR_CTRL_START])
					start_pend <= 1'b1;
				if (avs_writedata[`ISR_CTRL_STOP])
					stop_pend <= 1'b1;
				if (avs_writedata[`ISR_CTRL_RELEASE])
					release_pend <= 1'b1;
			end
			if (event_pulse && stop_detected_flag)
				events[`ISR_EV_STOP] <= 1'b1;
			if (!ctrl[`ISR_CTRL_EN] && state != ST_IDLE) begin
				state             <= ST_IDLE;
				controller_enable <= 1'b0;
				start_pend        <= 1'b0;
				stop_pend         <= 1'b0;
				slave_active      <= 1'b0;
			end else begin
				case (state)
					ST_IDLE: begin
						// Clock selection only follows software while disabled
						{clock_extend_select, speed_mode_select, clock_select_hi, clock_select_lo}
							<= ctrl[`ISR_CTRL_CLK_HI:`ISR_CTRL_CLK_LO];
						reservation_disable      <= ctrl[`ISR_CTRL_RSVDIS];
						initial_bus_state_option <= ctrl[`ISR_CTRL_STCEN];
						first_start              <= 1'b1;
						if (ctrl[`ISR_CTRL_EN])
							state <= ST_ENABLE;
					end
					ST_ENABLE: begin
						if (lines == 2'b11) begin
							controller_enable <= 1'b1;
							stop_pend         <= 1'b0;
							state <= initial_bus_state_option ? ST_READY : ST_FREE;
						end
					end
					ST_FREE: begin
						// Busy reads set after enable; a stop request frees it
						if (!stop_pend) begin
							stop_request <= 1'b1;
							stop_pend    <= 1'b1;
						end else if (!stop_request && !bus_busy_flag) begin
							stop_pend <= 1'b0;
							state     <= ST_READY;
						end
					end
					ST_READY: begin
						if (release_pend) begin
							release_pend        <= 1'b0;
							bus_release_request <= 1'b1;
							slave_active        <= 1'b0;
						end else if (start_pend && (!need_idle || bus_idle)) begin
							start_pend      <= 1'b0;
							first_start     <= 1'b0;
							// Stop interrupt lets a reserved start resume transfer
							stop_irq_enable <= 1'b1;
							start_request   <= 1'b1;
							state           <= ST_START;
						end else if (stop_pend) begin
							stop_pend    <= 1'b0;
							stop_request <= 1'b1;
						end
					end
					ST_START: begin
						timer_load  <= 1'b1;
						timer_count <= reservation_disable ? reject_wait(clk_sel[1:0])
							: master_wait(clk_sel);
						state       <= ST_WAITFLAG;
					end
					ST_WAITFLAG: begin
						if (timer_done) begin
							if (reservation_disable && start_rejected_flag) begin
								outcome <= 3'h4;
								events[`ISR_EV_REJECTED] <= 1'b1;
								state <= ST_READY;
							end else if (master_state_flag) begin
								outcome <= 3'h1;
								events[`ISR_EV_MASTER] <= 1'b1;
								state <= ST_MASTER;
							end else begin
								outcome <= 3'h2;
								events[`ISR_EV_RESERVED] <= 1'b1;
								state <= ST_RESERVED;
							end
						end
					end
					ST_RESERVED: begin
						// Data stays queued until the stop interrupt frees the bus
						if (event_pulse && stop_detected_flag) begin
							outcome <= 3'h1;
							events[`ISR_EV_MASTER] <= 1'b1;
							state <= ST_MASTER;
						end
					end
					ST_MASTER: begin
						if (stop_pend) begin
							stop_pend    <= 1'b0;
							stop_request <= 1'b1;
							state        <= ST_READY;
						end else if (start_pend) begin
							start_pend    <= 1'b0;
							start_request <= 1'b1;
							state         <= ST_START;
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
			// Forward a queued byte only when a write is valid
			if (tx_pending && !shift_data_write &&
				(state == ST_MASTER || (slave_active && transmit_direction_flag))) begin
				shift_data_reg   <= tx_byte;
				shift_data_write <= 1'b1;
				tx_pending       <= 1'b0;
			end
			// Slave side handshake when the controller is not master
			if (event_pulse && state == ST_READY && !master_state_flag) begin
				if (stop_detected_flag) begin
					slave_active <= 1'b0;
					ack_enable   <= 1'b1;
				end else if (!slave_active && start_detected_flag) begin
					slave_active <= 1'b1;
					slv_rx_left  <= slv_rx_count;
					ack_enable   <= (slv_rx_count != 8'h00);
					events[`ISR_EV_SLV_TX] <= transmit_direction_flag;
				end else if (slave_active && transmit_direction_flag) begin
					if (ack_detected_flag) begin
						events[`ISR_EV_SLV_TX] <= 1'b1;
					end else begin
						slave_active <= 1'b0;
						events[`ISR_EV_SLV_DONE] <= 1'b1;
					end
				end else if (slave_active) begin
					rx_data <= shift_data_in;
					if (slv_rx_left != 8'h00)
						slv_rx_left <= slv_rx_left - 8'h01;
					// Withhold acknowledge on the byte after the last wanted one
					ack_enable <= (slv_rx_left > 8'h01);
					if (slv_rx_left <= 8'h01)
						events[`ISR_EV_SLV_DONE] <= 1'b1;
					shift_data_write <= 1'b0;
				end
			end
		end
	end
endmodule // isr_ctrl
`default_nettype wire

// file: isr_ctrl_sva.sv
// Port assertions for the start and reservation host controller
`timescale 1ns/100ps
`default_nettype none
module isr_ctrl_sva (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// Host side
	input wire logic avs_waitrequest,
	input wire logic irq,
	// Bus lines
	input wire logic serial_clock_line,
	input wire logic serial_data_line,
	// Device controls
	input wire logic controller_enable,
	input wire logic initial_bus_state_option,
	input wire logic stop_irq_enable,
	input wire logic clock_extend_select,
	input wire logic speed_mode_select,
	input wire logic clock_select_hi,
	input wire logic clock_select_lo,
	input wire logic start_request,
	input wire logic stop_request,
	input wire logic bus_release_request,
	input wire logic shift_data_write,
	// Device status
	input wire logic master_state_flag,
	input wire logic transmit_direction_flag
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	logic [7:0] since_start;
	// Cycles since the last start request, saturating
	always @(posedge clk_sys) begin
		if (!resetn || start_request)
			since_start <= 8'h00;
		else if (since_start != 8'hFF)
			since_start <= since_start + 8'h01;
	end
	a_enable_lines_high: assert property ($rose(controller_enable) |-> serial_clock_line && serial_data_line)
		else $error("enable raised while a bus line was low");
	a_clock_sel_frozen: assert property (controller_enable && $past(controller_enable)
		|-> $stable({clock_extend_select, speed_mode_select, clock_select_hi, clock_select_lo}))
		else $error("clock select changed while enabled");
	a_start_single: assert property (start_request |=> !start_request)
		else $error("start request held two cycles");
	a_stop_single: assert property (stop_request |=> !stop_request)
		else $error("stop request held two cycles");
	a_release_single: assert property (bus_release_request |=> !bus_release_request)
		else $error("release request held two cycles");
	a_start_stop_irq: assert property (start_request |-> stop_irq_enable)
		else $error("start issued without stop interrupt enabled");
	a_tx_gated: assert property (shift_data_write |-> master_state_flag || transmit_direction_flag)
		else $error("data written while not transmitting");
	a_outcome_wait: assert property ($rose(irq) |-> since_start >= 8'h03)
		else $error("outcome reported before the minimum wait");
	a_init_stop: assert property ($rose(controller_enable) && !initial_bus_state_option
		|-> ##[0:20] stop_request)
		else $error("no stop request after enable with option zero");
	a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
endmodule // isr_ctrl_sva

bind isr_ctrl isr_ctrl_sva u_sva (.clk_sys, .resetn, .avs_waitrequest, .irq, .serial_clock_line,
	.serial_data_line, .controller_enable, .initial_bus_state_option, .stop_irq_enable,
	.clock_extend_select, .speed_mode_select, .clock_select_hi, .clock_select_lo, .start_request,
	.stop_request, .bus_release_request, .shift_data_write, .master_state_flag, .transmit_direction_flag);
`default_nettype wire

// file: isr_defines.vh
// Constants of the start and reservation host controller
// Overview of operation
// - Wait the clock-select dependent period before reading master state flag.
// - Wait the clock-select dependent period before checking start-rejected flag.
// - To free the bus: clock select, then enable, then stop request.
// - Initial option 1 reads idle; confirm bus really free before first start.
// - Enable the controller only while clock and data lines are both high.
// - Program clock select before enable; change it only after disabling.
// - Start and stop request bits must be cleared before set again.
// - With a reservation, enable stop interrupt; then data write releases wait.
// - Transmitting slave supplies bytes while master acknowledges; ends without acknowledge.
// - Receiving slave withholds acknowledge after last byte; master then stops.
`ifndef ISR_DEFINES_VH
`define ISR_DEFINES_VH

// Register word indices
`define ISR_REG_CTRL      3'h0
`define ISR_REG_STATUS    3'h1
`define ISR_REG_TXDATA    3'h2
`define ISR_REG_IRQ_STAT  3'h3
`define ISR_REG_IRQ_MASK  3'h4
`define ISR_REG_SLV_CFG   3'h5
`define ISR_REG_RXDATA    3'h6

// Control field positions
`define ISR_CTRL_EN       0
`define ISR_CTRL_RSVDIS   1
`define ISR_CTRL_STCEN    2
`define ISR_CTRL_MULTI    3
`define ISR_CTRL_CLK_LO   4
`define ISR_CTRL_CLK_HI   7
`define ISR_CTRL_START    8
`define ISR_CTRL_STOP     9
`define ISR_CTRL_RELEASE  10
`define ISR_CTRL_RESET    11'h000

// Interrupt event bit positions
`define ISR_EV_MASTER     0
`define ISR_EV_RESERVED   1
`define ISR_EV_REJECTED   2
`define ISR_EV_STOP       3
`define ISR_EV_SLV_TX     4
`define ISR_EV_SLV_DONE   5
`define ISR_EV_W          6

// Master state flag wait periods in fxx clocks, index {clx,smc,cl1,cl0}
`define ISR_MW_0          8'h2E
`define ISR_MW_1          8'h56
`define ISR_MW_2          8'h2B
`define ISR_MW_3          8'h66
`define ISR_MW_45         8'h1E
`define ISR_MW_6          8'h0F
`define ISR_MW_7          8'h24
`define ISR_MW_CD         8'h12
`define ISR_MW_E          8'h09

// Start rejected flag wait periods in fxx clocks, index {cl1,cl0}
`define ISR_RW_HALF       8'h06
`define ISR_RW_FULL       8'h03
`define ISR_RW_THIRD      8'h09

// Bus idle frame: nine link clocks of 800 ns, system clock 100 ns
`define ISR_FRAME_NS      7200
`define ISR_CLK_NS        100

`endif

// file: isr_dev_model.sv
// Behavioural model of the two-wire bus controller driven by the host
`timescale 1ns/100ps
`default_nettype none
module isr_dev_model (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	// Other bus traffic, from the bench
	input  wire logic       others_active,
	// Controls
	input  wire logic       controller_enable,
	input  wire logic       reservation_disable,
	input  wire logic       initial_bus_state_option,
	input  wire logic       stop_irq_enable,
	input  wire logic       start_request,
	input  wire logic       stop_request,
	input  wire logic       bus_release_request,
	input  wire logic       shift_data_write,
	input  wire logic [7:0] shift_data_reg,
	// Status and lines
	output wire logic       serial_clock_line,
	output wire logic       serial_data_line,
	output logic            master_state_flag,
	output logic            start_detected_flag,
	output logic            start_rejected_flag,
	output logic            bus_busy_flag,
	output logic            stop_detected_flag,
	output logic            transfer_event_irq,
	output logic [7:0]      last_byte
);
	logic [4:0] tick;
	logic       reserved, en_q, oa_q;
	// Foreign traffic toggles the clock line at 800 ns and holds data low
	assign serial_clock_line = others_active ? tick[2] : 1'h1;
	assign serial_data_line  = !others_active;
	always @(posedge clk_sys) begin
		tick <= resetn ? tick + 5'h01 : 5'h00;
		transfer_event_irq <= 1'h0;
		en_q <= controller_enable;
		oa_q <= others_active;
		if (!resetn) begin
			{master_state_flag, start_detected_flag, start_rejected_flag} <= 3'h0;
			{bus_busy_flag, stop_detected_flag, reserved} <= 3'h0;
			last_byte <= 8'h00;
		end else begin
			if (controller_enable && !en_q)
				bus_busy_flag <= !initial_bus_state_option;
			if (others_active && !oa_q) begin
				{bus_busy_flag, start_detected_flag, master_state_flag} <= 3'h6;
			end
			if ((oa_q && !others_active) || (stop_request && !others_active)) begin
				// A pending reservation takes the bus at the stop
				bus_busy_flag <= reserved;
				master_state_flag <= reserved;
				reserved <= 1'h0;
				start_detected_flag <= 1'h0;
				stop_detected_flag <= 1'h1;
				transfer_event_irq <= stop_irq_enable;
			end
			if (start_request) begin
				{start_rejected_flag, stop_detected_flag} <= 2'h0;
				if (!bus_busy_flag)
					{master_state_flag, bus_busy_flag} <= 2'h3;
				else if (reservation_disable)
					start_rejected_flag <= 1'h1;
				else
					reserved <= 1'h1;
			end
			if (bus_release_request)
				{master_state_flag, reserved} <= 2'h0;
			if (shift_data_write && !reserved)
				last_byte <= shift_data_reg;
		end
	end
endmodule // isr_dev_model
`default_nettype wire

// file: isr_sync.v
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module isr_sync #(
	parameter WIDTH = 2
) (
	// Clock and reset
	input  wire             clk_sys,
	input  wire             resetn,
	// Data
	input  wire [WIDTH-1:0] async_in,
	output reg  [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] stage1;

	always @(posedge clk_sys) begin
		if (!resetn) begin
			stage1   <= {WIDTH{1'b1}};
			sync_out <= {WIDTH{1'b1}};
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // isr_sync
`default_nettype wire

// file: isr_timer.v
// Down-counting wait timer with a one-cycle done pulse
`timescale 1ns/100ps
`default_nettype none
module isr_timer #(
	parameter WIDTH = 8
) (
	// Clock and reset
	input  wire             clk_sys,
	input  wire             resetn,
	// Control
	input  wire             load,
	input  wire [WIDTH-1:0] count,
	output reg              done
);
	reg [WIDTH-1:0] remain;
	reg             running;

	always @(posedge clk_sys) begin
		if (!resetn) begin
			remain  <= {WIDTH{1'b0}};
			running <= 1'b0;
			done    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				remain  <= count;
				running <= 1'b1;
			end else if (running) begin
				if (remain <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
					running <= 1'b0;
					done    <= 1'b1;
				end else begin
					remain <= remain - {{(WIDTH-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // isr_timer
`default_nettype wire

// file: tb_top.sv
// Testbench for the start and reservation host controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic        clk_sys = 1'h0, resetn = 1'h0, others_active = 1'h1;
	logic [2:0]  avs_address = 3'h0;
	logic        avs_read = 1'h0, avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0, d;
	logic        ack_detected_flag = 1'h0, transmit_direction_flag = 1'h0;
	logic [7:0]  shift_data_in = 8'h00;
	wire  [31:0] avs_readdata;
	wire  [7:0]  shift_data_reg, last_byte;
	wire         avs_waitrequest, irq, serial_clock_line, serial_data_line, controller_enable;
	wire         reservation_disable, initial_bus_state_option, stop_irq_enable, clock_extend_select;
	wire         speed_mode_select, clock_select_hi, clock_select_lo, start_request, stop_request;
	wire         bus_release_request, shift_data_write, ack_enable, master_state_flag, start_detected_flag;
	wire         start_rejected_flag, bus_busy_flag, stop_detected_flag, transfer_event_irq;
	integer      n_errors = 0, checked = 0, n_wr = 0, n;

	isr_ctrl #(.FRAME_CYCLES(8)) uut (.clk_sys, .resetn, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .serial_clock_line, .serial_data_line,
		.controller_enable, .reservation_disable, .initial_bus_state_option, .stop_irq_enable,
		.clock_extend_select, .speed_mode_select, .clock_select_hi, .clock_select_lo, .start_request,
		.stop_request, .bus_release_request, .shift_data_write, .shift_data_reg, .ack_enable,
		.master_state_flag, .start_detected_flag, .start_rejected_flag, .bus_busy_flag,
		.stop_detected_flag, .ack_detected_flag, .transmit_direction_flag, .transfer_event_irq,
		.shift_data_in);
	isr_dev_model dev (.clk_sys, .resetn, .others_active, .controller_enable, .reservation_disable,
		.initial_bus_state_option, .stop_irq_enable, .start_request, .stop_request, .bus_release_request,
		.shift_data_write, .shift_data_reg, .serial_clock_line, .serial_data_line, .master_state_flag,
		.start_detected_flag, .start_rejected_flag, .bus_busy_flag, .stop_detected_flag,
		.transfer_event_irq, .last_byte);

	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (shift_data_write === 1'h1) n_wr <= n_wr + 1;

	task conclude;
		begin
			$display("Comparisons %0d, mismatches %0d", checked, n_errors);
			if (n_errors == 0 && checked > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp) begin
				n_errors = n_errors + 1;
				$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	// One Avalon access; the request stands until waitrequest is sampled low
	task av(input logic is_rd, input logic [2:0] a, input logic [31:0] wd);
		begin
			avs_address <= a;
			avs_writedata <= wd;
			avs_read <= is_rd;
			avs_write <= !is_rd;
			@(posedge clk_sys);
			while (avs_waitrequest !== 1'h0) @(posedge clk_sys);
			d = avs_readdata;
			avs_read <= 1'h0;
			avs_write <= 1'h0;
			@(posedge clk_sys);
		end
	endtask
	task wr(input logic [2:0] a, input logic [31:0] v);
		av(1'h0, a, v);
	endtask
	task rd(input logic [2:0] a);
		av(1'h1, a, 32'h0);
	endtask
	task wait_irq;
		begin
			n = 0;
			while (irq !== 1'h1) begin
				@(posedge clk_sys);
				n = n + 1;
			end
		end
	endtask

	initial begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'h1;
		@(posedge clk_sys);
		chk({irq, controller_enable, ack_enable}, 32'h1);
		rd(3'h7);
		chk(d, 32'h0);
		$display("test reset done");
		// Enable with option zero and clock code 0010 while others hold the bus
		wr(3'h0, 32'h21);
		repeat (20) @(posedge clk_sys);
		chk(controller_enable, 32'h0);
		others_active <= 1'h0;
		while (controller_enable !== 1'h1) @(posedge clk_sys);
		repeat (4) @(posedge clk_sys);
		rd(3'h1);
		chk(d[4], 32'h0);
		chk(controller_enable, 32'h1);
		$display("test enable done");
		// Start on a free bus: master after the 43-clock wait
		wr(3'h4, 32'h07);
		wr(3'h0, 32'h121);
		wait_irq;
		chk(n >= 42, 32'h1);
		rd(3'h1);
		chk({d[5], d[3:0]}, 32'h19);
		wr(3'h3, 32'h3F);
		repeat (2) @(posedge clk_sys);
		chk(irq, 32'h0);
		wr(3'h0, 32'h421);
		wr(3'h0, 32'h221);
		repeat (10) @(posedge clk_sys);
		$display("test start done");
		// Start while others own the bus: reservation, byte held until stop
		others_active <= 1'h1;
		repeat (10) @(posedge clk_sys);
		wr(3'h0, 32'h121);
		wait_irq;
		rd(3'h1);
		chk(d[2:0], 32'h2);
		wr(3'h3, 32'h3F);
		wr(3'h2, 32'hA5);
		repeat (20) @(posedge clk_sys);
		rd(3'h1);
		chk({d[6], d[3]}, 32'h2);
		chk(n_wr, 32'h0);
		others_active <= 1'h0;
		while (n_wr == 0) @(posedge clk_sys);
		chk(last_byte, 32'hA5);
		rd(3'h3);
		chk(d[3], 32'h1);
		wr(3'h3, 32'h3F);
		wr(3'h0, 32'h221);
		repeat (10) @(posedge clk_sys);
		$display("test reservation done");
		// Reservation disabled: start on an occupied bus is rejected
		wr(3'h0, 32'h22);
		wr(3'h0, 32'h23);
		repeat (10) @(posedge clk_sys);
		others_active <= 1'h1;
		repeat (10) @(posedge clk_sys);
		wr(3'h0, 32'h123);
		wait_irq;
		rd(3'h1);
		chk(d[2:0], 32'h4);
		chk(n_wr, 32'h1);
		others_active <= 1'h0;
		wr(3'h3, 32'h3F);
		$display("test reject done");
		// Clock select frozen while enabled, applied once disabled
		wr(3'h0, 32'h31);
		repeat (4) @(posedge clk_sys);
		chk(clock_select_lo, 32'h0);
		wr(3'h0, 32'h30);
		repeat (4) @(posedge clk_sys);
		chk({controller_enable, clock_select_lo}, 32'h1);
		rd(3'h4);
		chk(d[5:0], 32'h07);
		$display("test clock select done");
		conclude;
	end

	// The tests need about 300 cycles
	initial begin
		#(5000 * 100);
		n_errors = n_errors + 1;
		conclude;
	end
endmodule // tb_top
`default_nettype wire
